/* rtl/delay_timer.sv */
`default_nettype none

module delay_timer
  import led_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [24:0] value,
  output logic [24:0] count,
  output logic done
);

  typedef struct packed {
    logic [24:0] cnt;
  } timer_type;

  timer_type t_reg;
  timer_type t_next;

  // A load of N makes done fire so that the owner acts N edges later.
  always_comb begin
    t_next = t_reg;
    if (load) begin
      t_next.cnt = value;
    end else if (t_reg.cnt != 25'h0000000) begin
      t_next.cnt = t_reg.cnt - 25'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t_reg <= '{cnt: 25'h0000000};
    end else if (ce) begin
      t_reg <= t_next;
    end
  end

  assign count = t_reg.cnt;
  assign done = (t_reg.cnt == 25'h0000001);

endmodule

`default_nettype wire

/* rtl/flash_torch_led_current_control.sv */
// What this block does
// [R1] Register enable starts ramp after 560 us.
// [R2] Register disable starts ramp-down 120 us after stop.
// [R3] Flash pin: up after 560 us, down 8 us.
// [R4] Torch pin: up after 560 us, down 8 us.
// [R5] Sync rise cuts after 3 us, fall restores 2 us.
// [R6] Flash: 128 levels, nibble ceiling, seven-bit level.
// [R7] Flash from mode bits or flash pin.
// [R8] Flash ramps through every step to target.
// [R9] Secondary gets ceiling minus primary level.
// [R10] Primary above ceiling: clamp, secondary off.
// [R11] Flash completion clears mode bits; host re-arms.
// [R12] Torch: 128 levels, three-bit ceiling, seven-bit level.
// [R13] Torch from mode bits or pin, stepped ramp.
// [R14] Torch split and clamp like flash.
// [R15] Torch never times out.
// [R16] Precharge with sources off until output ready.
// [R17] Start in pass, boost on low headroom.
// [R18] Sync high forces torch level during flash.
// [R19] Timeout turns current off despite sync.
// [R20] Sync input ignored when sync enable clear.
// [R21] Eight timeouts, 50 to 400 ms.
// [R22] Timeout clears mode bits, sets flag.
// [R23] One step per ramp tick; counter delays.
// [R24] Sync fallback uses torch ceiling and split.
`default_nettype none

module flash_torch_led_current_control
  import led_ctl_pkg::*;
#(
  parameter int ON_DELAY_CYCLES = CYC_ON_DEF,
  parameter int OFF_REG_DELAY_CYCLES = CYC_OFF_REG_DEF,
  parameter int TIMEOUT_STEP_CYCLES = CYC_TIMEOUT_STEP_DEF
)
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic FLASH_TRIG,
  input wire logic TORCH_TRIG,
  input wire logic PA_SYNC,
  input wire logic VOUT_READY,
  input wire logic HEADROOM_LOW,
  output logic [6:0] PRIMARY_CODE,
  output logic [6:0] SECONDARY_CODE,
  output logic SOURCES_ON,
  output logic PRECHARGE_ON,
  output logic BOOST_ON
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] f;
    logic [1:0] fp;
    logic pin_req_d;
    ctl_state_type st;
    logic is_flash;
    logic flash_block;
    logic src_on;
    logic boost;
    logic [6:0] prim;
    logic [6:0] sec;
    logic [5:0] ramp_cnt;
    logic [24:0] to_cnt;
    logic tx_app;
    logic tx_pend;
    logic [7:0] mode;
    logic [7:0] mode_pend;
    logic pend_v;
    logic [7:0] timing;
    logic [7:0] ceil;
    logic [7:0] flvl;
    logic [7:0] tlvl;
    logic [7:0] flags;
    bus_state_type bst;
    logic [3:0] nbit;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic drive;
  } state_type;

  localparam state_type STATE_RST = '{
    s1: 7'h00, s2: 7'h00, s3: 7'h00, f: 7'h00, fp: 2'h0,
    pin_req_d: 1'b0, st: ST_IDLE, is_flash: 1'b0, flash_block: 1'b0,
    src_on: 1'b0, boost: 1'b0, prim: 7'h00, sec: 7'h00,
    ramp_cnt: 6'h00, to_cnt: 25'h0000000, tx_app: 1'b0, tx_pend: 1'b0,
    mode: MODE_RST, mode_pend: MODE_RST, pend_v: 1'b0,
    timing: TIMING_RST, ceil: CEILING_RST, flvl: FLASH_LVL_RST,
    tlvl: TORCH_LVL_RST, flags: 8'h00, bst: B_IDLE, nbit: 4'h0,
    shift: 8'h00, ptr: 8'h00, rw: 1'b0, drive: 1'b0
  };

  state_type s_reg;
  state_type s_next;

  logic scl_rise, scl_fall, bus_start, bus_stop, sda;
  logic flash_w, torch_w, req, ramp_tick, timeout, use_torch, tx_req;
  logic lit;
  logic [6:0] fceil_code, tceil_code, cap, lvl, pt_tgt, st_tgt;
  logic [24:0] to_lim, tmr_val, tx_val, tmr_cnt, tx_cnt;
  logic tmr_load, tx_load, tmr_done, tx_done;
  logic [7:0] rd_byte;

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == REG_MODE) begin
      r = s_reg.mode;
    end else if (a == REG_TIMING) begin
      r = s_reg.timing;
    end else if (a == REG_CEILING) begin
      r = s_reg.ceil;
    end else if (a == REG_FLASH_LVL) begin
      r = s_reg.flvl;
    end else if (a == REG_TORCH_LVL) begin
      r = s_reg.tlvl;
    end else if (a == REG_FLAGS) begin
      r = s_reg.flags;
    end
    return r;
  endfunction

  function automatic logic [6:0] step(input logic [6:0] cur,
                                      input logic [6:0] goal);
    logic [6:0] r;
    r = cur;
    if (cur < goal) begin
      r = cur + 7'h01;
    end else if (cur > goal) begin
      r = cur - 7'h01;
    end
    return r;
  endfunction

  // ==========================================================================
  // Derived terms
  // ==========================================================================
  assign sda = s_reg.f[IN_SDA];
  assign scl_rise = s_reg.f[IN_SCL] & ~s_reg.fp[0];
  assign scl_fall = ~s_reg.f[IN_SCL] & s_reg.fp[0];
  assign bus_start = s_reg.f[IN_SCL] & s_reg.fp[0] & ~sda & s_reg.fp[1];
  assign bus_stop = s_reg.f[IN_SCL] & s_reg.fp[0] & sda & ~s_reg.fp[1];
  assign rd_byte = reg_read(s_reg.ptr);

  // Ceiling fields widen to the full code range of each mode.
  assign fceil_code = {s_reg.ceil[3:0], 3'h7}; // [R6]
  assign tceil_code = {s_reg.ceil[6:4], 4'hF}; // [R12]
  assign use_torch = ~s_reg.is_flash | s_reg.tx_app; // [R18] [R24]
  assign cap = use_torch ? tceil_code : fceil_code;
  assign lvl = use_torch ? s_reg.tlvl[6:0] : s_reg.flvl[6:0];
  assign pt_tgt = (lvl > cap) ? cap : lvl; // [R10] [R14]
  assign st_tgt = (lvl > cap) ? 7'h00 : cap - lvl; // [R9] [R14]

  assign flash_w = ((s_reg.mode[1:0] == MODE_FLASH) | s_reg.f[IN_FLASH])
    & ~s_reg.flash_block; // [R7]
  assign torch_w = (s_reg.mode[1:0] == MODE_TORCH)
    | s_reg.f[IN_TORCH]; // [R13]
  assign req = (s_reg.st == ST_IDLE) ? (flash_w | torch_w)
    : (s_reg.is_flash ? flash_w : torch_w);
  assign lit = (s_reg.st == ST_RUN) | (s_reg.st == ST_WAIT_OFF);
  assign ramp_tick = (s_reg.ramp_cnt == RAMP_CYCLES - 6'h01); // [R23]
  assign to_lim = 25'((int'(s_reg.timing[2:0]) + 1)
    * TIMEOUT_STEP_CYCLES); // [R21]
  assign timeout = s_reg.is_flash & lit
    & (s_reg.to_cnt == to_lim - 25'h0000001);
  assign tx_req = s_reg.f[IN_SYNC] & s_reg.mode[SYNC_EN_BIT]
    & s_reg.is_flash & lit & ~timeout; // [R20]

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_next = s_reg;
    tmr_load = 1'b0;
    tmr_val = 25'(ON_DELAY_CYCLES);
    tx_load = 1'b0;
    tx_val = 25'(CYC_SYNC_DOWN);

    // Only the second and third stages are compared, so a change counts
    // once it has been seen on two edges in a row.
    s_next.s1 = {HEADROOM_LOW, VOUT_READY, PA_SYNC, TORCH_TRIG, FLASH_TRIG,
                 SDA_IN, SCL};
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.f = (s_reg.s2 & s_reg.s3) | (s_reg.f & (s_reg.s2 | s_reg.s3));
    s_next.fp = {sda, s_reg.f[IN_SCL]};

    // Serial slave. Mode writes wait for the stop so that every delay
    // measured from a command starts from its end.
    if (bus_stop) begin
      s_next.bst = B_IDLE;
      s_next.drive = 1'b0;
      if (s_reg.pend_v) begin
        s_next.mode = s_reg.mode_pend;
        s_next.pend_v = 1'b0;
      end
    end else if (bus_start) begin
      s_next.bst = B_ADDR;
      s_next.nbit = 4'h0;
      s_next.drive = 1'b0;
    end else if (scl_rise) begin
      if (s_reg.bst == B_ADDR || s_reg.bst == B_REG
          || s_reg.bst == B_WDATA) begin
        s_next.shift = {s_reg.shift[6:0], sda};
        s_next.nbit = s_reg.nbit + 4'h1;
      end else if (s_reg.bst == B_RDATA) begin
        s_next.nbit = s_reg.nbit + 4'h1;
      end else if (s_reg.bst == B_RACK && sda) begin
        s_next.bst = B_IDLE;
      end
    end else if (scl_fall) begin
      case (s_reg.bst)
        B_ADDR: begin
          if (s_reg.nbit == 4'h8) begin
            if (s_reg.shift[7:1] == DEV_ADDR) begin
              s_next.bst = B_ACK_A;
              s_next.drive = 1'b1;
              s_next.rw = s_reg.shift[0];
            end else begin
              s_next.bst = B_IDLE;
            end
          end
        end
        B_ACK_A, B_RACK: begin
          s_next.nbit = 4'h0;
          if (s_reg.bst == B_RACK || s_reg.rw) begin
            s_next.bst = B_RDATA;
            s_next.shift = rd_byte;
            s_next.drive = ~rd_byte[7];
            if (s_reg.ptr == REG_FLAGS) begin
              s_next.flags = 8'h00;
            end
          end else begin
            s_next.bst = B_REG;
            s_next.drive = 1'b0;
          end
        end
        B_REG: begin
          if (s_reg.nbit == 4'h8) begin
            s_next.ptr = s_reg.shift;
            s_next.bst = B_ACK_R;
            s_next.drive = 1'b1;
          end
        end
        B_ACK_R, B_ACK_W: begin
          s_next.bst = B_WDATA;
          s_next.drive = 1'b0;
          s_next.nbit = 4'h0;
        end
        B_WDATA: begin
          if (s_reg.nbit == 4'h8) begin
            if (s_reg.ptr == REG_MODE) begin
              s_next.mode_pend = s_reg.shift;
              s_next.pend_v = 1'b1;
            end else if (s_reg.ptr == REG_TIMING) begin
              s_next.timing = s_reg.shift;
            end else if (s_reg.ptr == REG_CEILING) begin
              s_next.ceil = s_reg.shift;
            end else if (s_reg.ptr == REG_FLASH_LVL) begin
              s_next.flvl = s_reg.shift;
            end else if (s_reg.ptr == REG_TORCH_LVL) begin
              s_next.tlvl = s_reg.shift;
            end
            s_next.ptr = s_reg.ptr + 8'h01;
            s_next.bst = B_ACK_W;
            s_next.drive = 1'b1;
          end
        end
        B_RDATA: begin
          if (s_reg.nbit == 4'h8) begin
            s_next.drive = 1'b0;
            s_next.bst = B_RACK;
            s_next.ptr = s_reg.ptr + 8'h01;
          end else begin
            s_next.shift = {s_reg.shift[6:0], 1'b0};
            s_next.drive = ~s_reg.shift[6];
          end
        end
        default: begin
          s_next.bst = B_IDLE;
        end
      endcase
    end

    // Control sequencer.
    s_next.pin_req_d = s_reg.f[IN_FLASH] | s_reg.f[IN_TORCH];
    s_next.ramp_cnt = ramp_tick ? 6'h00 : s_reg.ramp_cnt + 6'h01;
    if (~s_reg.f[IN_FLASH] && s_reg.mode[1:0] != MODE_FLASH) begin
      s_next.flash_block = 1'b0;
    end
    case (s_reg.st)
      ST_IDLE: begin
        s_next.boost = 1'b0; // [R17]
        if (req) begin
          s_next.is_flash = flash_w;
          s_next.st = ST_WAIT_ON;
          tmr_load = 1'b1; // [R1] [R3] [R4]
        end
      end
      ST_WAIT_ON: begin
        if (!req) begin
          s_next.st = ST_IDLE;
        end else if (tmr_done) begin
          s_next.st = ST_PRECHARGE;
        end
      end
      ST_PRECHARGE: begin
        if (!req) begin
          s_next.st = ST_IDLE;
        end else if (s_reg.f[IN_VOUT]) begin
          s_next.st = ST_RUN; // [R16]
          s_next.src_on = 1'b1;
        end
      end
      ST_RUN, ST_WAIT_OFF: begin
        if (timeout) begin
          s_next.st = ST_RAMP_DOWN; // [R19]
          s_next.flash_block = 1'b1;
          s_next.flags[TIMEOUT_FLAG_BIT] = 1'b1; // [R22]
          if (!(bus_stop && s_reg.pend_v)) begin
            s_next.mode[1:0] = MODE_OFF; // [R22]
          end
        end else if (s_reg.st == ST_RUN && !req) begin
          s_next.st = ST_WAIT_OFF;
          tmr_load = 1'b1;
          tmr_val = s_reg.pin_req_d ? 25'(CYC_OFF_PIN) // [R3] [R4]
            : 25'(OFF_REG_DELAY_CYCLES); // [R2]
        end else if (s_reg.st == ST_WAIT_OFF && req) begin
          s_next.st = ST_RUN;
        end else if (s_reg.st == ST_WAIT_OFF && tmr_done) begin
          s_next.st = ST_RAMP_DOWN;
        end
      end
      ST_RAMP_DOWN: begin
        if (s_reg.prim == 7'h00 && s_reg.sec == 7'h00) begin
          s_next.st = ST_IDLE;
          s_next.src_on = 1'b0;
          if (s_reg.is_flash && !(bus_stop && s_reg.pend_v)) begin
            s_next.mode[1:0] = MODE_OFF; // [R11]
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    // Pass until the headroom comparator asks for switching.
    if (s_reg.src_on && s_reg.f[IN_HEADROOM]) begin
      s_next.boost = 1'b1; // [R17]
    end

    // Current codes move one step per tick; outside the lit states the
    // goal is zero, so the ramp-down also walks every step.
    if (lit || s_reg.st == ST_RAMP_DOWN) begin
      if (ramp_tick) begin
        s_next.prim = step(s_reg.prim, lit ? pt_tgt : 7'h00); // [R8] [R13]
        s_next.sec = step(s_reg.sec, lit ? st_tgt : 7'h00); // [R23]
      end
    end else begin
      s_next.prim = 7'h00;
      s_next.sec = 7'h00;
    end

    s_next.to_cnt = (s_reg.is_flash && lit)
      ? s_reg.to_cnt + 25'h0000001 : 25'h0000000; // [R15]

    // Sync fallback with its own delays in each direction.
    if (!lit || !s_reg.mode[SYNC_EN_BIT]) begin
      s_next.tx_app = 1'b0; // [R20]
      s_next.tx_pend = 1'b0;
    end else if (tx_req != s_reg.tx_app) begin
      if (!s_reg.tx_pend) begin
        tx_load = 1'b1;
        tx_val = tx_req ? 25'(CYC_SYNC_DOWN) : 25'(CYC_SYNC_UP); // [R5]
        s_next.tx_pend = 1'b1;
      end else if (tx_done) begin
        s_next.tx_app = tx_req; // [R5] [R18]
        s_next.tx_pend = 1'b0;
      end
    end else begin
      s_next.tx_pend = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s_reg <= STATE_RST;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Timers and outputs
  // ==========================================================================
  delay_timer ctl_timer (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .load(tmr_load),
    .value(tmr_val),
    .count(tmr_cnt),
    .done(tmr_done)
  );

  delay_timer sync_timer (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .load(tx_load),
    .value(tx_val),
    .count(tx_cnt),
    .done(tx_done)
  );

  assign SDA_OUT = 1'b0;
  assign SDA_OE = s_reg.drive;
  assign PRIMARY_CODE = s_reg.prim;
  assign SECONDARY_CODE = s_reg.sec;
  assign SOURCES_ON = s_reg.src_on;
  assign PRECHARGE_ON = (s_reg.st == ST_PRECHARGE);
  assign BOOST_ON = s_reg.boost;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET || !CE);

  AST_ON_DELAY: assert property ( // [R1]
    (s_reg.st == ST_IDLE && req) |=> (tmr_cnt == ON_DELAY_CYCLES)
  ) else $error("on delay not loaded");
  AST_WAIT_ON_HOLD: assert property ( // [R3]
    (s_reg.st == ST_WAIT_ON && req && tmr_cnt > 25'h0000001)
      |=> (s_reg.st == ST_WAIT_ON) && !SOURCES_ON
  ) else $error("ramp began before on delay");
  AST_OFF_PIN: assert property ( // [R4]
    (s_reg.st == ST_RUN && !req && !timeout && s_reg.pin_req_d)
      |=> (s_reg.st == ST_WAIT_OFF) && (tmr_cnt == CYC_OFF_PIN)
  ) else $error("pin off delay wrong");
  AST_OFF_REG: assert property ( // [R2]
    (s_reg.st == ST_RUN && !req && !timeout && !s_reg.pin_req_d)
      |=> (tmr_cnt == OFF_REG_DELAY_CYCLES)
  ) else $error("register off delay wrong");
  AST_STEP_HOLD: assert property ( // [R8]
    (lit && !ramp_tick) |=> $stable(PRIMARY_CODE) && $stable(SECONDARY_CODE)
  ) else $error("code moved between ticks");
  AST_ONE_STEP: assert property ( // [R13]
    ramp_tick |=> (PRIMARY_CODE == $past(PRIMARY_CODE)
      || PRIMARY_CODE == $past(PRIMARY_CODE) + 7'h01
      || PRIMARY_CODE == $past(PRIMARY_CODE) - 7'h01)
  ) else $error("code jumped more than one step");
  AST_CEILING: assert property ( // [R9]
    (lit && !use_torch)
      |-> ({1'b0, pt_tgt} + {1'b0, st_tgt} <= {1'b0, fceil_code})
  ) else $error("flash sum above ceiling");
  AST_CLAMP: assert property ( // [R10]
    (lit && lvl > cap) |-> (pt_tgt == cap) && (st_tgt == 7'h00)
  ) else $error("primary not clamped");
  AST_TIMEOUT: assert property ( // [R22]
    timeout |=> s_reg.flags[TIMEOUT_FLAG_BIT]
      && (s_reg.st == ST_RAMP_DOWN) ##1 !lit
  ) else $error("timeout not handled");
  AST_TORCH_NO_TIMEOUT: assert property ( // [R15]
    !s_reg.is_flash |-> (s_reg.to_cnt == 25'h0000000) && !timeout
  ) else $error("torch timed");
  AST_SYNC_IGNORED: assert property ( // [R20]
    !s_reg.mode[SYNC_EN_BIT] |=> !s_reg.tx_app
  ) else $error("sync used while disabled");
  AST_SYNC_DOWN: assert property ( // [R5]
    (tx_req && !s_reg.tx_app && !s_reg.tx_pend)
      |=> (tx_cnt == CYC_SYNC_DOWN)
  ) else $error("sync down delay wrong");
  AST_PRECHARGE: assert property ( // [R16]
    (s_reg.st == ST_PRECHARGE)
      |-> PRECHARGE_ON && !SOURCES_ON && (PRIMARY_CODE == 7'h00)
  ) else $error("sources on during precharge");
  AST_PASS_START: assert property ( // [R17]
    (s_reg.st == ST_IDLE) |=> !BOOST_ON
  ) else $error("boost at start");

endmodule

`default_nettype wire

/* rtl/led_ctl_pkg.sv */
`default_nettype none

package led_ctl_pkg;

  // ==========================================================================
  // Clock and documented control delays
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 20;
  localparam int DLY_ON_US = 560;
  localparam int DLY_OFF_REG_US = 120;
  localparam int DLY_OFF_PIN_US = 8;
  localparam int DLY_SYNC_DOWN_US = 3;
  localparam int DLY_SYNC_UP_US = 2;
  localparam int RAMP_STEP_NS = 1000;
  localparam int TIMEOUT_STEP_MS = 50;

  // Least times, so each count but the timeout step rounds up to whole cycles.
  localparam int CYC_ON_DEF = (DLY_ON_US * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CYC_OFF_REG_DEF = (DLY_OFF_REG_US * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CYC_OFF_PIN = (DLY_OFF_PIN_US * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CYC_SYNC_DOWN = (DLY_SYNC_DOWN_US * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CYC_SYNC_UP = (DLY_SYNC_UP_US * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [5:0] RAMP_CYCLES = 6'((RAMP_STEP_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS);
  localparam int CYC_TIMEOUT_STEP_DEF = (TIMEOUT_STEP_MS * 1000000)
    / CLK_PERIOD_NS;

  // ==========================================================================
  // Register map, fields and values after reset
  // ==========================================================================
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_TIMING = 8'h04;
  localparam logic [7:0] REG_CEILING = 8'h05;
  localparam logic [7:0] REG_FLASH_LVL = 8'h06;
  localparam logic [7:0] REG_TORCH_LVL = 8'h07;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam int SYNC_EN_BIT = 3;
  localparam int TIMEOUT_FLAG_BIT = 0;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TORCH = 2'h2;
  localparam logic [1:0] MODE_FLASH = 2'h3;
  localparam logic [7:0] MODE_RST = 8'h08;
  localparam logic [7:0] TIMING_RST = 8'h07;
  localparam logic [7:0] CEILING_RST = 8'h7F;
  localparam logic [7:0] FLASH_LVL_RST = 8'h3F;
  localparam logic [7:0] TORCH_LVL_RST = 8'h3F;
  // Bus address value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2A;

  // ==========================================================================
  // Synchronised input positions and state encodings
  // ==========================================================================
  localparam int IN_SCL = 0;
  localparam int IN_SDA = 1;
  localparam int IN_FLASH = 2;
  localparam int IN_TORCH = 3;
  localparam int IN_SYNC = 4;
  localparam int IN_VOUT = 5;
  localparam int IN_HEADROOM = 6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_ON = 3'b001,
    ST_PRECHARGE = 3'b010,
    ST_RUN = 3'b011,
    ST_WAIT_OFF = 3'b100,
    ST_RAMP_DOWN = 3'b101
  } ctl_state_type;

  typedef enum logic [3:0] {
    B_IDLE = 4'b0000,
    B_ADDR = 4'b0001,
    B_ACK_A = 4'b0010,
    B_REG = 4'b0011,
    B_ACK_R = 4'b0100,
    B_WDATA = 4'b0101,
    B_ACK_W = 4'b0110,
    B_RDATA = 4'b0111,
    B_RACK = 4'b1000
  } bus_state_type;

endpackage

`default_nettype wire

/* test/flash_torch_led_current_control_tb.sv */
`default_nettype none
module flash_torch_led_current_control_tb
  import led_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, reset = 1'b1, trig_f = 1'b0, trig_t = 1'b0;
  logic pa = 1'b0, vout = 1'b0, hr = 1'b0, ramp_watch = 1'b0;
  logic ce = 1'b1;
  logic scl, sda_low, sda_out, sda_oe, src_on, pre_on, boost_on;
  logic [6:0] pri, sec, prev_pri;
  logic [7:0] q;
  wire logic sda_line;
  int n_errors = 0, checks_done = 0, cycles = 0;
  assign sda_line = !(sda_low || sda_oe);
  always #10 mclk = !mclk;
  flash_torch_led_current_control #(.ON_DELAY_CYCLES(40),
    .OFF_REG_DELAY_CYCLES(30), .TIMEOUT_STEP_CYCLES(2000)) dut_u (
    .MCLK(mclk), .RESET(reset), .CE(ce), .SCL(scl),
    .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .FLASH_TRIG(trig_f), .TORCH_TRIG(trig_t), .PA_SYNC(pa),
    .VOUT_READY(vout), .HEADROOM_LOW(hr), .PRIMARY_CODE(pri),
    .SECONDARY_CODE(sec), .SOURCES_ON(src_on), .PRECHARGE_ON(pre_on),
    .BOOST_ON(boost_on));
  led_ctl_host host_u (.clk(mclk), .sda(sda_line), .scl(scl),
    .sda_low(sda_low));
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_codes(input logic [6:0] p, input logic [6:0] s,
      input int lim);
    for (int i = 0; i < lim && !(pri === p && sec === s); i++) begin
      @(posedge mclk);
      #1;
    end
    chk("primary", {1'b0, p}, {1'b0, pri});
    chk("secondary", {1'b0, s}, {1'b0, sec});
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (ramp_watch && pri !== prev_pri && pri !== prev_pri + 7'h01
        && pri !== prev_pri - 7'h01)
      chk("ramp_step", {1'b0, prev_pri}, {1'b0, pri});
    prev_pri <= pri;
    if (cycles == 80000) begin
      n_errors++;
      $display("[FAIL] run_time expected end seen timeout");
      give_verdict();
    end
  end
  // ==========================================================
  // Reset, torch by pin, flash by register with sync fallback.
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset = 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk("primary_rst", 8'h00, {1'b0, pri});
    host_u.rd1(REG_CEILING, q);
    chk("ceiling_rst", 8'h7F, q);
    host_u.rd1(8'h02, q);
    chk("unmapped", 8'h00, q);
    $display("test reset done");
    trig_t = 1'b1;
    ramp_watch = 1'b1;
    repeat (30) @(posedge mclk);
    #1 chk("precharge_early", 8'h00, {7'h00, pre_on});
    repeat (30) @(posedge mclk);
    #1 chk("precharge", 8'h01, {7'h00, pre_on});
    chk("sources_pre", 8'h00, {7'h00, src_on});
    vout = 1'b1;
    hr = 1'b1;
    wait_codes(7'h3F, 7'h40, 5000);
    chk("boost", 8'h01, {7'h00, boost_on});
    trig_t = 1'b0;
    repeat (380) @(posedge mclk);
    #1 chk("torch_hold", 8'h3F, {1'b0, pri});
    wait_codes(7'h00, 7'h00, 5000);
    ramp_watch = 1'b0;
    $display("test torch done");
    host_u.wr1(REG_CEILING, 8'h12);
    host_u.wr1(REG_TORCH_LVL, 8'h08);
    host_u.wr1(REG_MODE, 8'h0B);
    chk("sources_early", 8'h00, {7'h00, src_on});
    wait_codes(7'h17, 7'h00, 3000);
    pa = 1'b1;
    wait_codes(7'h08, 7'h17, 2000);
    pa = 1'b0;
    wait_codes(7'h17, 7'h00, 2000);
    pa = 1'b1;
    wait_codes(7'h08, 7'h17, 2000);
    wait_codes(7'h00, 7'h00, 20000);
    pa = 1'b0;
    host_u.rd1(REG_FLAGS, q);
    chk("flags", 8'h01, q);
    host_u.rd1(REG_MODE, q);
    chk("mode", 8'h08, q);
    $display("test flash done");
    // A frozen clock enable must hold the on delay where it stands.
    host_u.wr1(REG_MODE, 8'h0A);
    ce = 1'b0;
    repeat (100) @(posedge mclk);
    #1 chk("ce_freeze", 8'h00, {7'h00, src_on});
    ce = 1'b1;
    wait_codes(7'h08, 7'h17, 3000);
    host_u.wr1(REG_MODE, 8'h08);
    chk("torch_off_hold", 8'h08, {1'b0, pri});
    wait_codes(7'h00, 7'h00, 1300);
    $display("test torch register done");
    host_u.wr1(REG_TIMING, 8'h00);
    host_u.wr1(REG_MODE, 8'h00);
    pa = 1'b1;
    trig_f = 1'b1;
    wait_codes(7'h17, 7'h00, 3000);
    wait_codes(7'h00, 7'h00, 3000);
    repeat (200) @(posedge mclk);
    #1 chk("flash_blocked", 8'h00, {1'b0, pri});
    trig_f = 1'b0;
    pa = 1'b0;
    $display("test flash pin done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* test/led_ctl_host.sv */
`default_nettype none
// ==========================================================
// Serial-bus host: open-drain, so a released line reads high.
module led_ctl_host
  import led_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Ten cycles a phase keeps clear of the six-cycle minimum.
  task automatic hp();
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask
  task automatic xfer(input logic b, output logic r);
    sda_low = !b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
    hp();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) xfer(d[i], q[i]);
    xfer(ack_in, ack);
  endtask
  // Mode bits are written afresh by the host for each enable.
  task automatic wr1(input logic [7:0] ra, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a);
    byte_io(ra, 1'b1, q, a);
    byte_io(d, 1'b1, q, a);
    stop();
  endtask
  task automatic rd1(input logic [7:0] ra, output logic [7:0] q);
    logic a;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a);
    byte_io(ra, 1'b1, q, a);
    start();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, q, a);
    byte_io(8'hFF, 1'b1, q, a);
    stop();
  endtask
endmodule
`default_nettype wire
